// *** rdsw_top.sv ***
// rdsw_top: receive descriptor ownership, buffer address and status writeback.
// assumes: descriptor fetch, receive path and memory writer share clk_sys;
// the memory writer stores wb_data into the current descriptor on wb_ready.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rdsw_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // descriptor fetch
  input  wire logic        desc_valid,
  input  wire logic [15:0] desc_word0,
  input  wire logic [15:0] desc_word1,
  output logic             desc_take,
  // receive path events
  input  wire logic        rx_buf_full,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_dribble,
  input  wire logic        rx_fifo_ovf,
  input  wire logic [11:0] rx_byte_cnt,
  // buffer in use
  output logic      [23:0] buf_addr,
  output logic             buf_active,
  // descriptor writeback
  output logic             wb_valid,
  output logic             wb_sel,
  output logic      [15:0] wb_data,
  input  wire logic        wb_ready
);
  // ----------------------------------------------------------------
  // state and flags
  // ----------------------------------------------------------------
  rdsw_pkg::rdsw_state_t state_r, state_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] cur_w0_r, cur_w1_r, pend_w0_r, pend_w1_r;
  logic [15:0] last_r;
  logic        framing_fault_r, overflow_loss_r, crc_r, chain_buffer_fault_r, stp_r, enp_r, cont_r;
  logic        framing_fault_nxt, overflow_loss_nxt, crc_nxt, chain_buffer_fault_nxt, enp_nxt, cont_nxt;
  logic [11:0] len_r, len_nxt;
  logic        ssm, lpbk, owned, err_sum;
  logic [15:0] stat_word;

  assign ssm   = ctrl_r[rdsw_pkg::SSM_BIT];
  assign lpbk  = ctrl_r[rdsw_pkg::LPBK_BIT];
  assign owned = desc_word1[rdsw_pkg::OWN_BIT];

  assign err_sum = framing_fault_r | overflow_loss_r | crc_r | chain_buffer_fault_r;

  function automatic logic [15:0] stat_fn(input logic e, input logic f,
                                          input logic o, input logic c,
                                          input logic b, input logic s,
                                          input logic n, input logic [7:0] h);
    stat_fn = {1'b0, e, f, o, c, b, s, n, h};
  endfunction

  // ownership bit written as zero with the status
  assign stat_word = stat_fn(err_sum, framing_fault_r, overflow_loss_r, crc_r, chain_buffer_fault_r,
                             stp_r, enp_r, cur_w1_r[7:0]);

  // ----------------------------------------------------------------
  // next state and status
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    framing_fault_nxt  = framing_fault_r;
    overflow_loss_nxt  = overflow_loss_r;
    crc_nxt   = crc_r;
    chain_buffer_fault_nxt  = chain_buffer_fault_r;
    enp_nxt   = enp_r;
    cont_nxt  = cont_r;
    len_nxt   = len_r;
    case (state_r)
      rdsw_pkg::ST_IDLE: begin
        // an owned descriptor means the host has emptied it
        if (desc_valid && owned) begin
          state_nxt = rdsw_pkg::ST_FILL;
        end
      end
      rdsw_pkg::ST_FILL: begin
        if (rx_fifo_ovf) begin
          // frame data lost, last_segment stays clear
          overflow_loss_nxt  = 1'b1;
          enp_nxt   = 1'b0;
          cont_nxt  = 1'b0;
          state_nxt = rdsw_pkg::ST_WB_LEN;
        end else if (rx_end) begin
          enp_nxt   = 1'b1;
          crc_nxt   = rx_crc_err;
          // dribble bits alone are not a framing fault
          framing_fault_nxt  = rx_crc_err & rx_dribble & ~lpbk;
          len_nxt   = rx_byte_cnt;
          cont_nxt  = 1'b0;
          state_nxt = rdsw_pkg::ST_WB_LEN;
        end else if (rx_buf_full) begin
          state_nxt = rdsw_pkg::ST_CHAIN;
        end
      end
      rdsw_pkg::ST_CHAIN: begin
        if (rx_fifo_ovf) begin
          // both faults arise at the same moment here
          chain_buffer_fault_nxt  = 1'b1;
          overflow_loss_nxt  = 1'b1;
          cont_nxt  = 1'b0;
          state_nxt = rdsw_pkg::ST_WB_LEN;
        end else if (desc_valid) begin
          // next buffer still belongs to the host
          chain_buffer_fault_nxt  = ~owned;
          cont_nxt  = owned;
          state_nxt = rdsw_pkg::ST_WB_LEN;
        end
      end
      rdsw_pkg::ST_WB_LEN: begin
        // length first, status and release second
        if (wb_ready) begin
          state_nxt = rdsw_pkg::ST_WB_STAT;
        end
      end
      rdsw_pkg::ST_WB_STAT: begin
        if (wb_ready) begin
          framing_fault_nxt  = 1'b0;
          overflow_loss_nxt  = 1'b0;
          crc_nxt   = 1'b0;
          chain_buffer_fault_nxt  = 1'b0;
          enp_nxt   = 1'b0;
          len_nxt   = 12'h000;
          state_nxt = cont_r ? rdsw_pkg::ST_FILL : rdsw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = rdsw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= rdsw_pkg::ST_IDLE;
      framing_fault_r  <= 1'b0;
      overflow_loss_r  <= 1'b0;
      crc_r   <= 1'b0;
      chain_buffer_fault_r  <= 1'b0;
      enp_r   <= 1'b0;
      cont_r  <= 1'b0;
      len_r   <= 12'h000;
    end else begin
      state_r <= state_nxt;
      framing_fault_r  <= framing_fault_nxt;
      overflow_loss_r  <= overflow_loss_nxt;
      crc_r   <= crc_nxt;
      chain_buffer_fault_r  <= chain_buffer_fault_nxt;
      enp_r   <= enp_nxt;
      cont_r  <= cont_nxt;
      len_r   <= len_nxt;
    end
  end

  // ----------------------------------------------------------------
  // descriptor capture
  // ----------------------------------------------------------------
  // unowned descriptors are consumed too, so the poller moves on
  assign desc_take = desc_valid && (state_r == rdsw_pkg::ST_IDLE ||
                     (state_r == rdsw_pkg::ST_CHAIN && !rx_fifo_ovf));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_w0_r  <= 16'h0000;
      cur_w1_r  <= 16'h0000;
      pend_w0_r <= 16'h0000;
      pend_w1_r <= 16'h0000;
      stp_r     <= 1'b0;
    end else if (state_r == rdsw_pkg::ST_IDLE && desc_valid && owned) begin
      cur_w0_r <= desc_word0;
      cur_w1_r <= desc_word1;
      // host owns first_segment in software mode
      stp_r    <= ssm ? desc_word1[rdsw_pkg::STP_BIT] : 1'b1;
    end else if (state_r == rdsw_pkg::ST_CHAIN && desc_valid && !rx_fifo_ovf) begin
      pend_w0_r <= desc_word0;
      pend_w1_r <= desc_word1;
    end else if (state_r == rdsw_pkg::ST_WB_STAT && wb_ready && cont_r) begin
      cur_w0_r <= pend_w0_r;
      cur_w1_r <= pend_w1_r;
      // later buffers of a chain are not first
      stp_r    <= ssm ? pend_w1_r[rdsw_pkg::STP_BIT] : 1'b0;
    end
  end

  // no alignment or length check on the buffer
  assign buf_addr   = {cur_w1_r[7:0], cur_w0_r};
  assign buf_active = (state_r == rdsw_pkg::ST_FILL);

  // ----------------------------------------------------------------
  // writeback
  // ----------------------------------------------------------------
  // writes happen only while the descriptor is still ours
  assign wb_valid = (state_r == rdsw_pkg::ST_WB_LEN) ||
                    (state_r == rdsw_pkg::ST_WB_STAT);
  assign wb_sel   = (state_r == rdsw_pkg::ST_WB_STAT);
  // both words come from flops; the length word's top bits are reserved zero
  assign wb_data  = wb_sel ? stat_word : {4'h0, len_r};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      last_r <= 16'h0000;
    end else if (wb_valid && wb_sel && wb_ready) begin
      last_r <= stat_word;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= rdsw_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == rdsw_pkg::REG_CTRL) begin
      ctrl_r <= reg_wdata & 16'h0021;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        rdsw_pkg::REG_CTRL:     reg_rdata <= ctrl_r;
        rdsw_pkg::REG_LAST:     reg_rdata <= last_r;
        rdsw_pkg::REG_BADDR_LO: reg_rdata <= cur_w0_r;
        rdsw_pkg::REG_BADDR_HI: reg_rdata <= {8'h00, cur_w1_r[7:0]};
        rdsw_pkg::REG_FLAGS:    reg_rdata <= {13'h0000, cont_r, buf_active, wb_valid};
        default:                reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  own_release_a: assert property (
    wb_valid && wb_sel |-> !wb_data[rdsw_pkg::OWN_BIT])
    else $error("ownership not cleared in status write");

  err_summary_a: assert property (
    wb_valid && wb_sel |-> wb_data[rdsw_pkg::ERR_BIT] == |wb_data[13:10])
    else $error("error summary mismatch");

  framing_cause_a: assert property (
    state_r == rdsw_pkg::ST_FILL && rx_end && !rx_fifo_ovf && !rx_crc_err
    |=> !framing_fault_r)
    else $error("framing fault without fcs error");

  framing_valid_a: assert property (
    wb_valid && wb_sel && wb_data[rdsw_pkg::FRAMING_FAULT_BIT]
    |-> wb_data[rdsw_pkg::ENP_BIT] && !wb_data[rdsw_pkg::OVERFLOW_LOSS_BIT])
    else $error("framing fault without last segment");

  overflow_seg_a: assert property (
    state_r == rdsw_pkg::ST_FILL && rx_fifo_ovf |=> overflow_loss_r && !enp_r)
    else $error("overflow not reported");

  crc_seg_a: assert property (
    wb_valid && wb_sel && wb_data[rdsw_pkg::CRC_BIT] |-> wb_data[rdsw_pkg::ENP_BIT])
    else $error("crc flag without last segment");

  chain_fault_a: assert property (
    state_r == rdsw_pkg::ST_CHAIN && desc_valid && !owned && !rx_fifo_ovf
    |=> state_r == rdsw_pkg::ST_WB_LEN && chain_buffer_fault_r)
    else $error("missing chain buffer fault");

  late_ovf_a: assert property (
    state_r == rdsw_pkg::ST_CHAIN && desc_valid && !owned && !rx_fifo_ovf
    |=> !overflow_loss_r)
    else $error("overflow reported after buffer error");

  first_seg_a: assert property (
    state_r == rdsw_pkg::ST_WB_STAT && wb_ready && cont_r && !ssm |=> !stp_r)
    else $error("first segment set on chained buffer");

  last_seg_a: assert property (
    state_r == rdsw_pkg::ST_FILL && rx_end && !rx_fifo_ovf
    |=> enp_r && state_r == rdsw_pkg::ST_WB_LEN)
    else $error("last segment not written");

  length_a: assert property (
    state_r == rdsw_pkg::ST_FILL && rx_end && !rx_fifo_ovf
    |=> len_r == $past(rx_byte_cnt))
    else $error("received length wrong");

  addr_form_a: assert property (
    state_r == rdsw_pkg::ST_IDLE && desc_valid && owned
    |=> buf_addr == {$past(desc_word1[7:0]), $past(desc_word0)})
    else $error("buffer address wrong");

  write_order_a: assert property (
    $rose(wb_sel) |-> $past(wb_valid) && !$past(wb_sel) && $past(wb_ready))
    else $error("status written before length");

  wb_hold_a: assert property (
    wb_valid && !wb_ready |=> wb_valid && $stable(wb_sel) && $stable(wb_data))
    else $error("writeback word changed while pending");

  release_quiet_a: assert property (
    wb_valid && wb_sel && wb_ready && !cont_r |=> !wb_valid && !buf_active)
    else $error("descriptor touched after release");

endmodule
`default_nettype wire

// *** rdsw_pkg.sv ***
// rdsw_pkg: constants shared by the receive descriptor status writeback block.
// assumes: descriptor words are 16 bits, register port data 16 bits wide.
`default_nettype none
package rdsw_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_LAST     = 8'h04;
  localparam logic [7:0] REG_BADDR_LO = 8'h08;
  localparam logic [7:0] REG_BADDR_HI = 8'h0C;
  localparam logic [7:0] REG_FLAGS    = 8'h10;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  // control bits
  localparam int SSM_BIT  = 5;
  localparam int LPBK_BIT = 0;
  // ----------------------------------------------------------------
  // rx_desc_word1 field positions
  // ----------------------------------------------------------------
  localparam int OWN_BIT  = 15;
  localparam int ERR_BIT  = 14;
  localparam int FRAMING_FAULT_BIT = 13;
  localparam int OVERFLOW_LOSS_BIT = 12;
  localparam int CRC_BIT  = 11;
  localparam int CHAIN_BUFFER_FAULT_BIT = 10;
  localparam int STP_BIT  = 9;
  localparam int ENP_BIT  = 8;
  localparam int LEN_W    = 12;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FILL, ST_CHAIN, ST_WB_LEN, ST_WB_STAT
  } rdsw_state_t;
endpackage
`default_nettype wire

// *** rdsw_host_model.sv ***
// rdsw_host_model: host side of the block, a descriptor queue and a memory writer.
// assumes: one clk_sys domain; the bench pushes descriptors and reads captured words.
`timescale 1ns/100ps
`default_nettype none
module rdsw_host_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // descriptor fetch
  output logic             desc_valid,
  output logic      [15:0] desc_word0,
  output logic      [15:0] desc_word1,
  input  wire logic        desc_take,
  // writeback
  input  wire logic        wb_valid,
  input  wire logic        wb_sel,
  input  wire logic [15:0] wb_data,
  output logic             wb_ready,
  // bench view
  input  wire logic        slow,
  output logic      [15:0] len_w,
  output logic      [15:0] stat_w,
  output var int           n_wb,
  output logic             order_bad
);
  logic [31:0] q[$];
  logic [1:0]  stall_r;
  logic        len_seen_r;
  // ----------------------------------------------------------------
  // descriptor offer
  // ----------------------------------------------------------------
  // emptied buffers and, for the chain fault, one still held by the host are pushed, first_segment set by the bench
  task automatic push(input logic [31:0] d);
    q.push_back(d);
  endtask
  // words held while offered; idle lines keep toggling, never stale
  always @(posedge clk_sys) begin
    if (desc_valid && desc_take && q.size() != 0) q.pop_front();
    if (!rst_n || q.size() == 0) begin
      desc_valid <= 1'b0;
      {desc_word1, desc_word0} <= ~{desc_word1, desc_word0};
    end else begin
      desc_valid <= 1'b1;
      {desc_word1, desc_word0} <= q[0];
    end
  end
  // ----------------------------------------------------------------
  // memory writer
  // ----------------------------------------------------------------
  // a slow host accepts every third cycle of a pending word
  assign wb_ready = wb_valid && (!slow || stall_r == 2'd2);
  always_ff @(posedge clk_sys) begin
    if (!wb_valid || wb_ready) stall_r <= 2'd0;
    else stall_r <= stall_r + 2'd1;
  end
  // status word must follow its length word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      n_wb       <= 0;
      order_bad  <= 1'b0;
      len_seen_r <= 1'b0;
    end else if (wb_valid && wb_ready) begin
      n_wb <= n_wb + 1;
      if (!wb_sel) begin
        len_w      <= wb_data;
        len_seen_r <= 1'b1;
      end else begin
        stat_w     <= wb_data;
        len_seen_r <= 1'b0;
        if (!len_seen_r) order_bad <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** rdsw_top_tb.sv ***
// rdsw_top_tb: self-checking bench for the receive descriptor writeback block.
// assumes: rdsw_host_model stands on the descriptor and writeback side.
`timescale 1ns/100ps
`default_nettype none
module rdsw_top_tb;
  logic        clk_sys, rst_n, reg_wr, reg_rd, desc_valid, desc_take, slow;
  logic        rx_buf_full, rx_end, rx_crc_err, rx_dribble, rx_fifo_ovf;
  logic        buf_active, wb_valid, wb_sel, wb_ready, order_bad;
  logic [7:0]  reg_addr;
  logic [11:0] rx_byte_cnt;
  logic [15:0] reg_wdata, reg_rdata, desc_word0, desc_word1, wb_data, len_w, stat_w;
  logic [23:0] buf_addr;
  int          n_wb, n_errors, total_checks;
  rdsw_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .desc_valid(desc_valid), .desc_word0(desc_word0), .desc_word1(desc_word1),
    .desc_take(desc_take), .rx_buf_full(rx_buf_full), .rx_end(rx_end),
    .rx_crc_err(rx_crc_err), .rx_dribble(rx_dribble), .rx_fifo_ovf(rx_fifo_ovf),
    .rx_byte_cnt(rx_byte_cnt), .buf_addr(buf_addr), .buf_active(buf_active),
    .wb_valid(wb_valid), .wb_sel(wb_sel), .wb_data(wb_data), .wb_ready(wb_ready));
  rdsw_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .desc_valid(desc_valid),
    .desc_word0(desc_word0), .desc_word1(desc_word1), .desc_take(desc_take),
    .wb_valid(wb_valid), .wb_sel(wb_sel), .wb_data(wb_data), .wb_ready(wb_ready),
    .slow(slow), .len_w(len_w), .stat_w(stat_w), .n_wb(n_wb), .order_bad(order_bad));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // e packs {buf_full, end, crc_err, dribble, fifo_ovf} into a one-cycle pulse
  task automatic ev(input logic [4:0] e, input logic [11:0] cnt);
    @(posedge clk_sys);
    {rx_buf_full, rx_end, rx_crc_err, rx_dribble, rx_fifo_ovf} <= e;
    rx_byte_cnt <= cnt;
    @(posedge clk_sys);
    {rx_buf_full, rx_end, rx_crc_err, rx_dribble, rx_fifo_ovf} <= 5'h00;
  endtask
  task automatic wait_act(input logic v);
    for (int i = 0; i < 50 && buf_active !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(buf_active, v);
  endtask
  task automatic wait_wb(input int n);
    for (int i = 0; i < 200 && n_wb < n; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(24'(n_wb), 24'(n));
  endtask
  task automatic frame(input logic [15:0] w0, w1, input logic [4:0] e,
                       input logic [11:0] cnt, input logic [15:0] es, el);
    int n0;
    n0 = n_wb;
    host.push({w1, w0});
    wait_act(1'b1);
    chk(buf_addr, {w1[7:0], w0});
    ev(e, cnt);
    wait_wb(n0 + 2);
    chk(stat_w, es);
    chk(len_w, el);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs;
    rd(rdsw_pkg::REG_CTRL, 16'h0000);
    wr(rdsw_pkg::REG_CTRL, 16'hffff);
    rd(rdsw_pkg::REG_CTRL, 16'h0021);
    rd(8'h20, 16'h0000);
    wr(rdsw_pkg::REG_CTRL, 16'h0000);
  endtask
  task automatic sc_frames;
    frame(16'h1235, 16'h82a5, 5'h08, 12'h040, 16'h03a5, 16'h0040);
    rd(rdsw_pkg::REG_LAST, 16'h03a5);
    rd(rdsw_pkg::REG_BADDR_LO, 16'h1235);
    rd(rdsw_pkg::REG_BADDR_HI, 16'h00a5);
    frame(16'h0003, 16'h8210, 5'h0e, 12'hfff, 16'h6b10, 16'h0fff);
    frame(16'h0004, 16'h8211, 5'h0a, 12'h001, 16'h0311, 16'h0001);
    slow <= 1'b1;
    frame(16'h0005, 16'h8212, 5'h0c, 12'h100, 16'h4b12, 16'h0100);
    slow <= 1'b0;
    frame(16'h0006, 16'h8213, 5'h01, 12'h123, 16'h5213, 16'h0000);
  endtask
  task automatic sc_modes;
    wr(rdsw_pkg::REG_CTRL, 16'h0001);
    frame(16'h0007, 16'h8220, 5'h0e, 12'h040, 16'h4b20, 16'h0040);
    wr(rdsw_pkg::REG_CTRL, 16'h0020);
    frame(16'h0008, 16'h8021, 5'h08, 12'h040, 16'h0121, 16'h0040);
    frame(16'h0009, 16'h8222, 5'h08, 12'h040, 16'h0322, 16'h0040);
    wr(rdsw_pkg::REG_CTRL, 16'h0000);
  endtask
  task automatic sc_chain_ok;
    int n0;
    n0 = n_wb;
    host.push({16'h82c3, 16'h0001});
    wait_act(1'b1);
    rd(rdsw_pkg::REG_FLAGS, 16'h0002);
    ev(5'h10, 12'h000);
    host.push({16'h8044, 16'hfffe});
    wait_wb(n0 + 2);
    chk(stat_w, 16'h02c3);
    wait_act(1'b1);
    chk(buf_addr, 24'h44fffe);
    ev(5'h08, 12'h5ee);
    wait_wb(n0 + 4);
    chk(stat_w, 16'h0144);
    chk(len_w, 16'h05ee);
  endtask
  task automatic chain_fault(input logic own_next, input logic [15:0] es);
    int n0;
    n0 = n_wb;
    host.push({16'h8255, 16'h0100});
    wait_act(1'b1);
    ev(5'h10, 12'h000);
    if (own_next) ev(5'h01, 12'h000);
    else host.push({16'h0066, 16'h0200});
    wait_wb(n0 + 2);
    chk(stat_w, es);
  endtask
  task automatic sc_chain_fault;
    chain_fault(1'b0, 16'h4655);
    chain_fault(1'b1, 16'h5655);
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    n_errors = 0;
    total_checks = 0;
    {rst_n, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
    {rx_buf_full, rx_end, rx_crc_err, rx_dribble, rx_fifo_ovf, rx_byte_cnt} = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_regs();
    sc_frames();
    sc_modes();
    sc_chain_ok();
    sc_chain_fault();
    chk(order_bad, 1'b0);
    finish_test();
  end
  // the full sequence needs a few hundred cycles; this bound of 20000 cycles leaves ample room
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
